//--- rtl/adc_readout_cfg.svh
// constants of the serial readout port
`ifndef ADC_READOUT_CFG_SVH
`define ADC_READOUT_CFG_SVH
`define RESULT_W        16
`define FORCED_LOW_EDGE 3'd5
`define CODE_ZERO       16'h0000
`define CODE_POS_FULL   16'h7fff
`define CODE_NEG_FULL   16'h8000
`endif

//--- rtl/adc_readout_pkg.sv
// types of the serial readout port
package adc_readout_pkg;
  typedef enum logic [1:0] {
    st_power_down,
    st_lead_in,
    st_shifting
  } frame_state_t;
endpackage

//--- rtl/word_buf_if.sv
// valid/ready word path between capture and shifter
`timescale 1ns/10ps
interface word_buf_if;
  logic        valid;
  logic        ready;
  logic [15:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

//--- rtl/word_buf2.sv
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/10ps
`include "adc_readout_cfg.svh"
module word_buf2
  import adc_readout_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic flush,
  word_buf_if.dst  up,
  word_buf_if.src  down
);
  typedef struct packed {
    logic [1:0][`RESULT_W-1:0] mem;
    logic                      rd;
    logic                      wr;
    logic [1:0]                cnt;
  } buf_state_t;

  buf_state_t s_reg;
  buf_state_t s_next;
  logic       push;
  logic       pop;

  assign up.ready   = (s_reg.cnt != 2'd2) && !flush;
  assign down.valid = (s_reg.cnt != 2'd0);
  assign down.data  = s_reg.mem[s_reg.rd];
  assign push       = up.valid && up.ready;
  assign pop        = down.valid && down.ready;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wr] = up.data;
      s_next.wr = ~s_reg.wr;
    end
    if (pop) begin
      s_next.rd = ~s_reg.rd;
    end
    s_next.cnt = s_reg.cnt + {1'b0, push} - {1'b0, pop};
    if (flush) begin
      s_next.cnt = 2'd0;
      s_next.rd  = 1'b0;
      s_next.wr  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  property p_no_overfill;
    @(posedge clk) disable iff (!nrst)
      (s_reg.cnt == 2'd2) |-> !up.ready;
  endproperty
  a_no_overfill: assert property (p_no_overfill)
    else $error("buffer accepts while full");

  // a word accepted from upstream must be offered downstream on the next cycle
  property p_word_kept;
    @(posedge clk) disable iff (!nrst)
      (up.valid && up.ready) |=> down.valid;
  endproperty
  a_word_kept: assert property (p_word_kept)
    else $error("accepted word not offered downstream");
endmodule

//--- rtl/adc_serial_readout.sv
// serial readout port of a 16-bit converter, device side
`timescale 1ns/10ps
`include "adc_readout_cfg.svh"
// Overview of operation
// - a falling select starts a conversion and the result transfer.
// - output stays undriven until the fifth clock fall, then goes low.
// - result bits follow MSB first, one per later clock fall.
// - each bit holds across the rising clock edge and changes only on the next clock fall.
// - the converter powers down by itself after each conversion.
// - the result is two's complement, clamped to 7fff and 8000.
// - each frame returns the sample taken by its own select fall.
module adc_serial_readout
  import adc_readout_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        convert_sel_n,
  input  wire logic        serial_shift_clock,
  input  wire logic signed [16:0] sample_diff,
  output logic             sample_req,
  output logic             converter_powered,
  output logic             dout_o,
  output logic             dout_oe_n,
  output logic             frame_active
);
  typedef struct packed {
    logic [1:0]          sel_sync;
    logic [1:0]          sck_sync;
    logic                sel_last;
    logic                sck_last;
    frame_state_t        state;
    logic [2:0]          lead_cnt;
    logic [4:0]          bits_left;
    logic [`RESULT_W-1:0] shift;
    logic                dout;
    logic                oe_n;
    logic                powered;
    logic                req;
    logic                cap_valid;
    logic [`RESULT_W-1:0] cap_data;
  } port_state_t;

  port_state_t s_reg;
  port_state_t s_next;
  word_buf_if  wb_in ();
  word_buf_if  wb_out ();
  logic        sel_fall;
  logic        sel_rise;
  logic        sck_fall;

  // clamp the wide difference into the 16-bit two's complement range
  function automatic logic [15:0] clamp_code(input logic signed [16:0] d);
    if (d > 17'sd32767) begin
      clamp_code = `CODE_POS_FULL;
    end else if (d < -17'sd32768) begin
      clamp_code = `CODE_NEG_FULL;
    end else begin
      clamp_code = d[15:0];
    end
  endfunction

  assign sel_fall = s_reg.sel_last && !s_reg.sel_sync[1];
  assign sel_rise = !s_reg.sel_last && s_reg.sel_sync[1];
  assign sck_fall = s_reg.sck_last && !s_reg.sck_sync[1];

  assign wb_in.valid  = s_reg.cap_valid;
  assign wb_in.data   = s_reg.cap_data;
  // the buffered word is taken exactly at the fifth fall
  assign wb_out.ready = (s_reg.state == st_lead_in) && sck_fall
                        && (s_reg.lead_cnt == `FORCED_LOW_EDGE - 3'd1);

  word_buf2 u_buf (
    .clk  (clk),
    .nrst (nrst),
    .flush(sel_fall),
    .up   (wb_in),
    .down (wb_out)
  );

  always_comb begin
    s_next = s_reg;
    s_next.sel_sync = {s_reg.sel_sync[0], convert_sel_n};
    s_next.sck_sync = {s_reg.sck_sync[0], serial_shift_clock};
    s_next.sel_last = s_reg.sel_sync[1];
    s_next.sck_last = s_reg.sck_sync[1];
    s_next.req = 1'b0;
    if (wb_in.ready) begin
      s_next.cap_valid = 1'b0;
    end
    // capture completes one cycle after the request: no stale sample
    if (s_reg.req) begin
      s_next.cap_data  = clamp_code(sample_diff);
      s_next.cap_valid = 1'b1;
      s_next.powered   = 1'b0;
    end
    case (s_reg.state)
      st_power_down: begin
        s_next.oe_n = 1'b1;
      end
      st_lead_in: begin
        if (sck_fall) begin
          s_next.lead_cnt = s_reg.lead_cnt + 3'd1;
          if (s_reg.lead_cnt == `FORCED_LOW_EDGE - 3'd1) begin
            s_next.oe_n  = 1'b0;
            s_next.dout  = 1'b0;
            // limitation: a word not yet buffered here goes out as zeros
            s_next.shift = wb_out.valid ? wb_out.data : `CODE_ZERO;
            s_next.bits_left = 5'd16;
            s_next.state = st_shifting;
          end
        end
      end
      st_shifting: begin
        // bit changes only on a fall, so it holds across the rise
        if (sck_fall && s_reg.bits_left != 5'd0) begin
          s_next.dout  = s_reg.shift[`RESULT_W-1];
          s_next.shift = {s_reg.shift[`RESULT_W-2:0], 1'b0};
          s_next.bits_left = s_reg.bits_left - 5'd1;
        end
      end
      default: begin
        s_next.state = st_power_down;
      end
    endcase
    if (sel_rise) begin
      s_next.state = st_power_down;
      s_next.oe_n  = 1'b1;
      s_next.dout  = 1'b0;
    end
    if (sel_fall) begin
      s_next.state    = st_lead_in;
      s_next.lead_cnt = 3'd0;
      s_next.oe_n     = 1'b1;
      s_next.req      = 1'b1;
      s_next.powered  = 1'b1;
      s_next.cap_valid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg          <= '0;
      s_reg.sel_sync <= 2'b11;
      s_reg.sel_last <= 1'b1;
      // pins idle high: matching history avoids a false edge
      s_reg.sck_sync <= 2'b11;
      s_reg.sck_last <= 1'b1;
      s_reg.oe_n     <= 1'b1;
      s_reg.state    <= st_power_down;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sample_req        = s_reg.req;
  assign converter_powered = s_reg.powered;
  assign dout_o            = s_reg.dout;
  assign dout_oe_n         = s_reg.oe_n;
  assign frame_active      = (s_reg.state != st_power_down);

  property p_quiet_lead;
    @(posedge clk) disable iff (!nrst)
      (s_reg.state == st_lead_in) |-> dout_oe_n;
  endproperty
  a_quiet_lead: assert property (p_quiet_lead)
    else $error("output driven before fifth fall");

  property p_forced_low;
    @(posedge clk) disable iff (!nrst)
      (s_reg.state == st_lead_in && sck_fall && !sel_rise && !sel_fall
       && s_reg.lead_cnt == `FORCED_LOW_EDGE - 3'd1)
      |=> (!dout_oe_n && !dout_o);
  endproperty
  a_forced_low: assert property (p_forced_low)
    else $error("forced low bit missing");

  property p_hold_bit;
    @(posedge clk) disable iff (!nrst)
      (s_reg.state == st_shifting && !sck_fall && !sel_rise && !sel_fall)
      |=> $stable(dout_o);
  endproperty
  a_hold_bit: assert property (p_hold_bit)
    else $error("bit changed off a falling edge");

  property p_start;
    @(posedge clk) disable iff (!nrst)
      sel_fall |=> (sample_req && s_reg.state == st_lead_in);
  endproperty
  a_start: assert property (p_start)
    else $error("select fall did not start frame");

  property p_release;
    @(posedge clk) disable iff (!nrst)
      (sel_rise && !sel_fall) |=> dout_oe_n;
  endproperty
  a_release: assert property (p_release)
    else $error("output not released at frame end");

  property p_power_down;
    @(posedge clk) disable iff (!nrst)
      sample_req |=> !converter_powered;
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("no power down after conversion");

  property p_fresh;
    @(posedge clk) disable iff (!nrst)
      sample_req |=> s_reg.cap_valid;
  endproperty
  a_fresh: assert property (p_fresh)
    else $error("capture not taken for this frame");

  property p_msb;
    @(posedge clk) disable iff (!nrst)
      (s_reg.state == st_shifting && sck_fall && s_reg.bits_left == 5'd16
       && !sel_rise && !sel_fall)
      |=> dout_o == $past(s_reg.shift[15]);
  endproperty
  a_msb: assert property (p_msb)
    else $error("msb not first");

  property p_clamp;
    @(posedge clk) disable iff (!nrst)
      (s_reg.req && sample_diff > 17'sd32767)
      |=> s_reg.cap_data == `CODE_POS_FULL;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("overrange not clamped");
endmodule

//--- dv/host_model.sv
// host model: drives select and shift clock, reads the data pin
`timescale 1ns/10ps
module host_model (
  input  wire logic clk,
  input  wire logic dout_o,
  input  wire logic dout_oe_n,
  output logic      convert_sel_n,
  output logic      serial_shift_clock
);
  logic line;
  // a released pin shows the inverse, so a stale bit never passes
  assign line = dout_oe_n ? ~dout_o : dout_o;
  initial begin
    convert_sel_n      = 1'b1;
    serial_shift_clock = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // clock idles high between frames; half period of 4 cycles
  task automatic frame(input bit sel, input int falls,
                       output logic [15:0] word, output int lead_err);
    logic lo_bit;
    word     = 16'h0000;
    lead_err = 0;
    tick(1);
    convert_sel_n = ~sel;
    tick(8);
    for (int f = 1; f <= falls; f++) begin
      serial_shift_clock = 1'b0;
      tick(4);
      lo_bit = line;
      serial_shift_clock = 1'b1;
      tick(3);
      // same bit must stand on both sides of the rising edge
      if (f > 5 && line !== lo_bit) lead_err++;
      if (f < 5 && dout_oe_n !== 1'b1) lead_err++;
      if (f == 5 && (dout_oe_n !== 1'b0 || line !== 1'b0)) lead_err++;
      // sampled late in the high phase, before the next fall
      if (f > 5) word = {word[14:0], line};
      tick(1);
    end
    convert_sel_n = 1'b1;
    tick(6);
  endtask
endmodule

//--- dv/adc_serial_readout_tb.sv
// self-checking bench of the serial readout port
`timescale 1ns/10ps
`include "adc_readout_cfg.svh"
module adc_serial_readout_tb;
  import adc_readout_pkg::*;
  logic               clk;
  logic               nrst;
  logic signed [16:0] sample_diff;
  logic               convert_sel_n;
  logic               serial_shift_clock;
  logic               sample_req;
  logic               converter_powered;
  logic               dout_o;
  logic               dout_oe_n;
  logic               frame_active;
  logic [15:0]        word;
  int                 lead_err;
  int                 bad_count;
  int                 total_checks;
  int                 cycles;
  int                 reqs;
  int                 pw;

  adc_serial_readout adc_serial_readout_i (.clk(clk), .nrst(nrst),
    .convert_sel_n(convert_sel_n), .serial_shift_clock(serial_shift_clock),
    .sample_diff(sample_diff), .sample_req(sample_req),
    .converter_powered(converter_powered), .dout_o(dout_o),
    .dout_oe_n(dout_oe_n), .frame_active(frame_active));
  host_model host_model_i (.clk(clk), .dout_o(dout_o), .dout_oe_n(dout_oe_n),
    .convert_sel_n(convert_sel_n), .serial_shift_clock(serial_shift_clock));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (sample_req === 1'b1) reqs++;
    if (converter_powered === 1'b1) pw++;
    if (cycles == 6000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check_val(input string name, input logic [15:0] exp,
                           input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic run_word(input logic signed [16:0] d, input logic [15:0] e,
                          input int falls);
    sample_diff = d;
    reqs = 0;
    pw = 0;
    host_model_i.frame(1'b1, falls, word, lead_err);
    check_val("lead", 16'h0000, 16'(lead_err));
    check_val("word", e, word);
    check_val("oe_n", 16'h0001, {15'h0000, dout_oe_n});
    check_val("busy", 16'h0000, {15'h0000, frame_active});
    check_val("reqs", 16'h0001, 16'(reqs));
    check_val("power", 16'h0001, 16'(pw));
  endtask

  // clock falls without select must not count toward the lead-in
  task automatic t_idle();
    reqs = 0;
    host_model_i.frame(1'b0, 4, word, lead_err);
    check_val("idle_reqs", 16'h0000, 16'(reqs));
    check_val("idle_lead", 16'h0000, 16'(lead_err));
    run_word(-17'sh00002, 16'hfffe, 21);
  endtask

  task automatic t_codes();
    logic signed [16:0] din [8];
    logic [15:0]        dexp [8];
    din  = '{17'sh00000, 17'sh07fff, -17'sh08000, 17'sh00001,
             -17'sh00001, -17'sh07fff, 17'sh09c40, -17'sh09c40};
    dexp = '{`CODE_ZERO, `CODE_POS_FULL, `CODE_NEG_FULL, 16'h0001,
             16'hffff, 16'h8001, `CODE_POS_FULL, `CODE_NEG_FULL};
    for (int i = 0; i < 8; i++) run_word(din[i], dexp[i], 21);
  endtask

  // frame cut short in mid-word, then a full one with a new sample
  task automatic t_abort();
    run_word(17'sh01234, 16'h0009, 12);
    run_word(17'sh00f0f, 16'h0f0f, 21);
  endtask

  initial begin
    nrst         = 1'b0;
    sample_diff  = 17'sh00000;
    bad_count    = 0;
    total_checks = 0;
    cycles       = 0;
    reqs         = 0;
    pw           = 0;
    repeat (5) @(posedge clk);
    #2;
    nrst = 1'b1;
    check_val("rst_oe_n", 16'h0001, {15'h0000, dout_oe_n});
    t_idle();
    t_codes();
    t_abort();
    give_verdict();
  end
endmodule
